/* File: dv/pcd_panel_model.sv */
`timescale 1ns/100ps
`default_nettype none
module pcd_panel_model (
  input  wire logic i_press_a,
  input  wire logic i_press_stop,
  input  wire logic i_press_b,
  input  wire logic i_bounce_a,
  output wire logic o_unlock_a_n,
  output wire logic o_stop_n,
  output wire logic o_unlock_b_n
);
  // pressed button or closed contact pulls its line low, released reads high
  assign o_unlock_a_n = ~(i_press_a | i_bounce_a);
  assign o_stop_n     = ~i_press_stop;
  assign o_unlock_b_n = ~i_press_b;
endmodule : pcd_panel_model
`default_nettype wire

/* File: dv/test_passage_command_decoder.sv */
`timescale 1ns/100ps
`default_nettype none
module test_passage_command_decoder;
  // state word is {open_a, free_a, open_b, free_b}
  localparam logic [3:0] LK = 4'h0;
  localparam logic [3:0] SA = 4'h8;
  localparam logic [3:0] FA = 4'hC;
  localparam logic [3:0] SB = 4'h2;
  localparam logic [3:0] FB = 4'h3;
  localparam logic [3:0] SS = 4'hA;
  localparam logic [3:0] FF = 4'hF;

  logic i_clock = 1'h0;
  logic i_nrst = 1'h0;
  logic press_a = 1'h0;
  logic press_s = 1'h0;
  logic press_b = 1'h0;
  logic bounce_a = 1'h0;
  logic i_pulse_mode = 1'h1;
  logic i_passage_a = 1'h0;
  logic i_passage_b = 1'h0;
  wire logic unlock_a_n;
  wire logic stop_n;
  wire logic unlock_b_n;
  wire logic o_open_a;
  wire logic o_open_b;
  wire logic o_free_a;
  wire logic o_free_b;
  wire logic [3:0] state_word;
  int fails = 0;
  int samples_checked = 0;

  always #20 i_clock = ~i_clock;

  assign state_word = {o_open_a, o_free_a, o_open_b, o_free_b};

  pcd_panel_model panel (
    .i_press_a    (press_a),
    .i_press_stop (press_s),
    .i_press_b    (press_b),
    .i_bounce_a   (bounce_a),
    .o_unlock_a_n (unlock_a_n),
    .o_stop_n     (stop_n),
    .o_unlock_b_n (unlock_b_n)
  );

  pcd_decoder #(
    .TIMEOUT_CYCLES  (40),
    .DEBOUNCE_CYCLES (4)
  ) dut (
    .i_clock      (i_clock),
    .i_nrst       (i_nrst),
    .i_unlock_a_n (unlock_a_n),
    .i_stop_n     (stop_n),
    .i_unlock_b_n (unlock_b_n),
    .i_pulse_mode (i_pulse_mode),
    .i_passage_a  (i_passage_a),
    .i_passage_b  (i_passage_b),
    .o_open_a     (o_open_a),
    .o_open_b     (o_open_b),
    .o_free_a     (o_free_a),
    .o_free_b     (o_free_b)
  );

  task automatic check(input logic [3:0] seen, input logic [3:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      fails++;
      $display("[ERR] %0t state %b expected %b", $time, seen, exp);
    end
  endtask : check

  // 1 = pressed; long enough for debounce plus decode latency
  task automatic set_in(input logic pa, input logic ps, input logic pb);
    @(posedge i_clock);
    press_a <= pa;
    press_s <= ps;
    press_b <= pb;
    repeat (10) @(posedge i_clock);
    #1;
  endtask : set_in

  task automatic pass_pulse(input logic on_b);
    @(posedge i_clock);
    i_passage_a <= ~on_b;
    i_passage_b <= on_b;
    @(posedge i_clock);
    i_passage_a <= 1'h0;
    i_passage_b <= 1'h0;
    repeat (2) @(posedge i_clock);
    #1;
  endtask : pass_pulse

  task automatic single_timeout;
    set_in(1, 0, 0);
    check(state_word, SA);
    set_in(0, 0, 0);
    check(state_word, SA);
    repeat (20) @(posedge i_clock);
    #1;
    check(state_word, SA);
    repeat (12) @(posedge i_clock);
    #1;
    check(state_word, LK);
  endtask : single_timeout

  task automatic single_passage;
    set_in(0, 0, 1);
    check(state_word, SB);
    set_in(0, 0, 0);
    set_in(1, 0, 0);
    check(state_word, SS);
    pass_pulse(1'h0);
    check(state_word, SB);
    // passage on B lands well before its timer runs out
    pass_pulse(1'h1);
    check(state_word, LK);
    set_in(0, 0, 0);
  endtask : single_passage

  task automatic free_a;
    set_in(0, 1, 0);
    check(state_word, LK);
    set_in(1, 1, 0);
    check(state_word, FA);
    set_in(0, 0, 0);
    set_in(1, 0, 0);
    check(state_word, FA);
    set_in(0, 0, 0);
    set_in(0, 1, 0);
    check(state_word, LK);
    set_in(0, 0, 0);
    set_in(1, 0, 0);
    set_in(1, 1, 0);
    check(state_word, FA);
    set_in(0, 0, 0);
    set_in(0, 1, 0);
    check(state_word, LK);
    set_in(0, 0, 0);
  endtask : free_a

  task automatic free_b;
    set_in(0, 1, 1);
    check(state_word, FB);
    set_in(0, 0, 0);
    set_in(0, 0, 1);
    check(state_word, FB);
    set_in(0, 0, 0);
    set_in(0, 1, 0);
    set_in(0, 0, 0);
    set_in(0, 0, 1);
    set_in(0, 1, 1);
    check(state_word, FB);
    set_in(0, 0, 0);
    set_in(0, 1, 0);
    check(state_word, LK);
    set_in(0, 0, 0);
  endtask : free_b

  task automatic both_single;
    set_in(1, 0, 0);
    set_in(1, 0, 1);
    check(state_word, SS);
    set_in(0, 0, 0);
    pass_pulse(1'h0);
    check(state_word, SS);
    repeat (30) @(posedge i_clock);
    #1;
    check(state_word, LK);
  endtask : both_single

  task automatic both_single_free;
    set_in(1, 1, 0);
    set_in(0, 0, 0);
    set_in(1, 0, 0);
    set_in(1, 0, 1);
    check(state_word, FA | SB);
    set_in(0, 0, 0);
    set_in(0, 1, 0);
    check(state_word, LK);
    set_in(0, 0, 0);
  endtask : both_single_free

  task automatic free_all;
    set_in(1, 0, 0);
    set_in(1, 0, 1);
    set_in(1, 1, 1);
    check(state_word, FF);
    set_in(0, 0, 0);
    set_in(0, 1, 0);
    check(state_word, LK);
    set_in(0, 0, 0);
    set_in(0, 1, 1);
    set_in(1, 1, 1);
    check(state_word, FF);
    set_in(0, 0, 0);
    set_in(0, 1, 0);
    set_in(0, 0, 0);
  endtask : free_all

  task automatic glitch;
    @(posedge i_clock);
    bounce_a <= 1'h1;
    repeat (2) @(posedge i_clock);
    bounce_a <= 1'h0;
    repeat (12) @(posedge i_clock);
    #1;
    check(state_word, LK);
  endtask : glitch

  task automatic potential;
    @(posedge i_clock);
    i_pulse_mode <= 1'h0;
    set_in(1, 0, 0);
    check(state_word, FA);
    set_in(1, 0, 1);
    check(state_word, FF);
    set_in(1, 1, 1);
    check(state_word, LK);
    set_in(0, 0, 1);
    check(state_word, FB);
    set_in(0, 0, 0);
    check(state_word, LK);
    @(posedge i_clock);
    i_pulse_mode <= 1'h1;
  endtask : potential

  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : complete_run

  initial
  begin
    repeat (10) @(posedge i_clock);
    i_nrst <= 1'h1;
    repeat (2) @(posedge i_clock);
    #1;
    check(state_word, LK);
    single_timeout();
    single_passage();
    free_a();
    free_b();
    both_single();
    both_single_free();
    free_all();
    glitch();
    potential();
    complete_run();
  end

  initial
  begin
    repeat (20000) @(posedge i_clock);
    fails++;
    complete_run();
  end
endmodule : test_passage_command_decoder
`default_nettype wire

/* File: verilog/pcd_debounce.sv */
`timescale 1ns/100ps
`default_nettype none
module pcd_debounce #(
  parameter int unsigned STABLE_CYCLES = pcd_pkg::DEBOUNCE_CYCLES
) (
  input  wire logic i_clock,
  input  wire logic i_nrst,
  input  wire logic i_raw,
  output var  logic o_level,
  output var  logic o_fall
);
  localparam int unsigned CW = $clog2(STABLE_CYCLES + 1);
  localparam logic [CW-1:0] LAST = CW'(STABLE_CYCLES - 1);
  localparam logic [CW-1:0] ZERO = '0;

  logic          sync1_reg;
  logic          sync2_reg;
  logic [CW-1:0] count_reg;
  logic          update;

  assign update = (sync2_reg != o_level) && (count_reg == LAST);

  always_ff @(posedge i_clock or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      sync1_reg <= pcd_pkg::LEVEL_IDLE;
      sync2_reg <= pcd_pkg::LEVEL_IDLE;
    end
    else
    begin
      sync1_reg <= i_raw;
      sync2_reg <= sync1_reg;
    end
  end

  // a level must stand unbroken for the whole window before it counts
  always_ff @(posedge i_clock or negedge i_nrst)
  begin
    if (!i_nrst)
      count_reg <= ZERO;
    else if (sync2_reg == o_level || update)
      count_reg <= ZERO;
    else
      count_reg <= count_reg + CW'(1);
  end

  always_ff @(posedge i_clock or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      o_level <= pcd_pkg::LEVEL_IDLE;
      o_fall  <= 1'h0;
    end
    else
    begin
      if (update)
        o_level <= sync2_reg;
      o_fall <= update && !sync2_reg;
    end
  end

  property p_fall_is_edge;
    @(posedge i_clock) disable iff (!i_nrst)
    o_fall |-> !o_level && $past(o_level);
  endproperty
  a_fall_is_edge: assert property (p_fall_is_edge)
    else $error("fall pulse without a high to low change");

  property p_change_needs_window;
    @(posedge i_clock) disable iff (!i_nrst)
    $changed(o_level) |-> $past(count_reg) == LAST && $past(sync2_reg) == o_level;
  endproperty
  a_change_needs_window: assert property (p_change_needs_window)
    else $error("debounced level changed before the window ran out");
endmodule : pcd_debounce
`default_nettype wire

/* File: verilog/pcd_decoder.sv */
`timescale 1ns/100ps
`default_nettype none
module pcd_decoder #(
  parameter int unsigned TIMEOUT_CYCLES  = pcd_pkg::TIMEOUT_CYCLES,
  parameter int unsigned DEBOUNCE_CYCLES = pcd_pkg::DEBOUNCE_CYCLES
) (
  input  wire logic i_clock,
  input  wire logic i_nrst,
  input  wire logic i_unlock_a_n,
  input  wire logic i_stop_n,
  input  wire logic i_unlock_b_n,
  input  wire logic i_pulse_mode,
  input  wire logic i_passage_a,
  input  wire logic i_passage_b,
  output var  logic o_open_a,
  output var  logic o_open_b,
  output var  logic o_free_a,
  output var  logic o_free_b
);
  logic                 lvl_a;
  logic                 lvl_s;
  logic                 lvl_b;
  logic                 fall_a;
  logic                 fall_s;
  logic                 fall_b;
  logic                 exp_a;
  logic                 exp_b;
  logic                 pulse;
  logic                 cmd_lock;
  logic                 cmd_single_a;
  logic                 cmd_single_b;
  logic                 cmd_single_both;
  logic                 cmd_free_a;
  logic                 cmd_free_b;
  logic                 cmd_free_both;
  logic                 load_a;
  logic                 load_b;
  logic                 cancel_a;
  logic                 cancel_b;
  logic                 pass_end_a_reg;
  logic                 pass_end_b_reg;
  logic                 pass_end_a_next;
  logic                 pass_end_b_next;
  pcd_pkg::pcd_dir_type state_a_reg;
  pcd_pkg::pcd_dir_type state_b_reg;
  pcd_pkg::pcd_dir_type state_a_next;
  pcd_pkg::pcd_dir_type state_b_next;

  pcd_debounce #(.STABLE_CYCLES(DEBOUNCE_CYCLES)) u_deb_a (
    .i_clock (i_clock),
    .i_nrst  (i_nrst),
    .i_raw   (i_unlock_a_n),
    .o_level (lvl_a),
    .o_fall  (fall_a)
  );

  pcd_debounce #(.STABLE_CYCLES(DEBOUNCE_CYCLES)) u_deb_s (
    .i_clock (i_clock),
    .i_nrst  (i_nrst),
    .i_raw   (i_stop_n),
    .o_level (lvl_s),
    .o_fall  (fall_s)
  );

  pcd_debounce #(.STABLE_CYCLES(DEBOUNCE_CYCLES)) u_deb_b (
    .i_clock (i_clock),
    .i_nrst  (i_nrst),
    .i_raw   (i_unlock_b_n),
    .o_level (lvl_b),
    .o_fall  (fall_b)
  );

  pcd_timer #(.CYCLES(TIMEOUT_CYCLES)) u_tmr_a (
    .i_clock   (i_clock),
    .i_nrst    (i_nrst),
    .i_load    (load_a),
    .i_cancel  (cancel_a),
    .o_expired (exp_a)
  );

  pcd_timer #(.CYCLES(TIMEOUT_CYCLES)) u_tmr_b (
    .i_clock   (i_clock),
    .i_nrst    (i_nrst),
    .i_load    (load_b),
    .i_cancel  (cancel_b),
    .o_expired (exp_b)
  );

  assign pulse = (i_pulse_mode == pcd_pkg::MODE_PULSE);

  // each edge is read against the present levels of the other two inputs
  assign cmd_lock        = pulse && fall_s && lvl_a && lvl_b;
  assign cmd_single_a    = pulse && fall_a && lvl_s && lvl_b;
  assign cmd_single_b    = pulse && fall_b && lvl_s && lvl_a;
  assign cmd_single_both = pulse && lvl_s
                         && ((fall_a && !lvl_b) || (fall_b && !lvl_a));
  assign cmd_free_a      = pulse && ((fall_a && !lvl_s && lvl_b)
                         || (fall_s && !lvl_a && lvl_b));
  assign cmd_free_b      = pulse && ((fall_b && !lvl_s && lvl_a)
                         || (fall_s && !lvl_b && lvl_a));
  assign cmd_free_both   = pulse && ((fall_a && !lvl_b && !lvl_s)
                         || (fall_b && !lvl_a && !lvl_s)
                         || (fall_s && !lvl_a && !lvl_b));

  // next state of one direction in pulse mode; lock beats free beats single
  function automatic pcd_pkg::pcd_dir_type dir_step(
    input pcd_pkg::pcd_dir_type cur,
    input logic                 lock,
    input logic                 free,
    input logic                 single,
    input logic                 ends_on_pass,
    input logic                 passage,
    input logic                 expired
  );
    pcd_pkg::pcd_dir_type nxt;
    nxt = cur;
    if (lock)
      nxt = pcd_pkg::dir_locked;
    else if (free)
      nxt = pcd_pkg::dir_free;
    else if (single && cur != pcd_pkg::dir_free)
      nxt = pcd_pkg::dir_single;
    else if (cur == pcd_pkg::dir_single && (expired || (ends_on_pass && passage)))
      nxt = pcd_pkg::dir_locked;
    return nxt;
  endfunction : dir_step

  always_comb
  begin
    if (pulse)
    begin
      state_a_next = dir_step(state_a_reg, cmd_lock, cmd_free_a || cmd_free_both,
                              cmd_single_a || cmd_single_both, pass_end_a_reg,
                              i_passage_a, exp_a);
      state_b_next = dir_step(state_b_reg, cmd_lock, cmd_free_b || cmd_free_both,
                              cmd_single_b || cmd_single_both, pass_end_b_reg,
                              i_passage_b, exp_b);
    end
    else
    begin
      // levels alone decide; stop low or both opens high closes both
      state_a_next = (lvl_s && !lvl_a) ? pcd_pkg::dir_free
                                       : pcd_pkg::dir_locked;
      state_b_next = (lvl_s && !lvl_b) ? pcd_pkg::dir_free
                                       : pcd_pkg::dir_locked;
    end
  end

  // the both-direction single passage ignores passage pulses and ends on time, lock or free
  always_comb
  begin
    pass_end_a_next = pass_end_a_reg;
    pass_end_b_next = pass_end_b_reg;
    if (state_a_next == pcd_pkg::dir_single && state_a_reg != pcd_pkg::dir_free)
    begin
      if (cmd_single_a)
        pass_end_a_next = 1'h1;
      else if (cmd_single_both)
        pass_end_a_next = 1'h0;
    end
    if (state_b_next == pcd_pkg::dir_single && state_b_reg != pcd_pkg::dir_free)
    begin
      if (cmd_single_b)
        pass_end_b_next = 1'h1;
      else if (cmd_single_both)
        pass_end_b_next = 1'h0;
    end
  end

  assign load_a   = state_a_next == pcd_pkg::dir_single && (cmd_single_a || cmd_single_both)
                  && state_a_reg != pcd_pkg::dir_free;
  assign load_b   = state_b_next == pcd_pkg::dir_single && (cmd_single_b || cmd_single_both)
                  && state_b_reg != pcd_pkg::dir_free;
  assign cancel_a = state_a_reg == pcd_pkg::dir_single && state_a_next != pcd_pkg::dir_single;
  assign cancel_b = state_b_reg == pcd_pkg::dir_single && state_b_next != pcd_pkg::dir_single;

  always_ff @(posedge i_clock or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      state_a_reg    <= pcd_pkg::dir_locked;
      state_b_reg    <= pcd_pkg::dir_locked;
      pass_end_a_reg <= 1'h0;
      pass_end_b_reg <= 1'h0;
    end
    else
    begin
      state_a_reg    <= state_a_next;
      state_b_reg    <= state_b_next;
      pass_end_a_reg <= pass_end_a_next;
      pass_end_b_reg <= pass_end_b_next;
    end
  end

  always_ff @(posedge i_clock or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      o_open_a <= 1'h0;
      o_open_b <= 1'h0;
      o_free_a <= 1'h0;
      o_free_b <= 1'h0;
    end
    else
    begin
      o_open_a <= state_a_next != pcd_pkg::dir_locked;
      o_open_b <= state_b_next != pcd_pkg::dir_locked;
      o_free_a <= state_a_next == pcd_pkg::dir_free;
      o_free_b <= state_b_next == pcd_pkg::dir_free;
    end
  end

  sequence s_both_closed;
    !o_open_a && !o_open_b;
  endsequence

  sequence s_single_a_open;
    o_open_a && !o_free_a;
  endsequence

  sequence s_single_b_open;
    o_open_b && !o_free_b;
  endsequence

  property p_lock;
    @(posedge i_clock) disable iff (!i_nrst)
    cmd_lock |=> s_both_closed;
  endproperty
  a_lock: assert property (p_lock)
    else $error("lock command did not close both directions");

  property p_single_a;
    @(posedge i_clock) disable iff (!i_nrst)
    cmd_single_a && !o_free_a && !cmd_free_both && !exp_b && !i_passage_b
      |=> s_single_a_open
      ##0 ((o_open_b == $past(o_open_b)) && (o_free_b == $past(o_free_b)));
  endproperty
  a_single_a: assert property (p_single_a)
    else $error("single passage A not opened or B disturbed");

  property p_ignore_a;
    @(posedge i_clock) disable iff (!i_nrst)
    (cmd_single_a || cmd_single_both) && o_free_a && !cmd_lock |=> o_free_a;
  endproperty
  a_ignore_a: assert property (p_ignore_a)
    else $error("single passage command downgraded free A");

  property p_single_b;
    @(posedge i_clock) disable iff (!i_nrst)
    cmd_single_b && !o_free_b && !cmd_free_both && !exp_a && !i_passage_a
      |=> s_single_b_open
      ##0 ((o_open_a == $past(o_open_a)) && (o_free_a == $past(o_free_a)));
  endproperty
  a_single_b: assert property (p_single_b)
    else $error("single passage B not opened or A disturbed");

  property p_ignore_b;
    @(posedge i_clock) disable iff (!i_nrst)
    (cmd_single_b || cmd_single_both) && o_free_b && !cmd_lock |=> o_free_b;
  endproperty
  a_ignore_b: assert property (p_ignore_b)
    else $error("single passage command downgraded free B");

  property p_single_both;
    @(posedge i_clock) disable iff (!i_nrst)
    cmd_single_both && !o_free_a && !o_free_b |=> s_single_a_open ##0 s_single_b_open;
  endproperty
  a_single_both: assert property (p_single_both)
    else $error("both-direction single passage did not open both");

  property p_single_ends;
    @(posedge i_clock) disable iff (!i_nrst)
    pulse && state_a_reg == pcd_pkg::dir_single && exp_a
      && !cmd_single_a && !cmd_single_both && !cmd_free_a && !cmd_free_both
      |=> !o_open_a;
  endproperty
  a_single_ends: assert property (p_single_ends)
    else $error("single passage A outlived its timeout");

  property p_free_a;
    @(posedge i_clock) disable iff (!i_nrst)
    cmd_free_a && !exp_b && !i_passage_b
      |=> o_free_a && o_open_a && (o_open_b == $past(o_open_b));
  endproperty
  a_free_a: assert property (p_free_a)
    else $error("free passage A not set");

  property p_free_b;
    @(posedge i_clock) disable iff (!i_nrst)
    cmd_free_b && !exp_a && !i_passage_a
      |=> o_free_b && o_open_b && (o_open_a == $past(o_open_a));
  endproperty
  a_free_b: assert property (p_free_b)
    else $error("free passage B not set");

  property p_free_both;
    @(posedge i_clock) disable iff (!i_nrst)
    cmd_free_both |=> o_free_a && o_free_b;
  endproperty
  a_free_both: assert property (p_free_both)
    else $error("free passage both not set");

  property p_pot_close;
    @(posedge i_clock) disable iff (!i_nrst)
    !pulse && ((lvl_a && lvl_b) || !lvl_s) |=> s_both_closed;
  endproperty
  a_pot_close: assert property (p_pot_close)
    else $error("potential mode failed to close both directions");

  property p_pot_a;
    @(posedge i_clock) disable iff (!i_nrst)
    !pulse && !lvl_a && lvl_s && lvl_b |=> o_open_a && !o_open_b;
  endproperty
  a_pot_a: assert property (p_pot_a)
    else $error("potential mode did not hold A open");

  property p_pot_b;
    @(posedge i_clock) disable iff (!i_nrst)
    !pulse && !lvl_b && lvl_s && lvl_a |=> o_open_b && !o_open_a;
  endproperty
  a_pot_b: assert property (p_pot_b)
    else $error("potential mode did not hold B open");

  property p_pot_both;
    @(posedge i_clock) disable iff (!i_nrst)
    !pulse && !lvl_a && !lvl_b && lvl_s |=> o_open_a && o_open_b;
  endproperty
  a_pot_both: assert property (p_pot_both)
    else $error("potential mode did not hold both open");
endmodule : pcd_decoder
`default_nettype wire

/* File: verilog/pcd_pkg.sv */
`default_nettype none
package pcd_pkg;
  localparam int unsigned CLOCK_HZ        = 25_000_000;
  localparam int unsigned TIMEOUT_S       = 5;
  localparam int unsigned TIMEOUT_CYCLES  = TIMEOUT_S * CLOCK_HZ;
  localparam int unsigned DEBOUNCE_MS     = 10;
  localparam int unsigned DEBOUNCE_CYCLES = DEBOUNCE_MS * (CLOCK_HZ / 1000);
  // released button or open contact reads high
  localparam logic        LEVEL_IDLE      = 1'h1;
  localparam logic        MODE_PULSE      = 1'h1;

  typedef enum logic [1:0] {dir_locked, dir_single, dir_free} pcd_dir_type;
endpackage : pcd_pkg
`default_nettype wire

/* File: verilog/pcd_timer.sv */
`timescale 1ns/100ps
`default_nettype none
module pcd_timer #(
  parameter int unsigned CYCLES = pcd_pkg::TIMEOUT_CYCLES
) (
  input  wire logic i_clock,
  input  wire logic i_nrst,
  input  wire logic i_load,
  input  wire logic i_cancel,
  output var  logic o_expired
);
  localparam int unsigned CW = $clog2(CYCLES + 1);
  localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);
  localparam logic [CW-1:0] ZERO = '0;

  logic [CW-1:0] count_reg;
  logic          run_reg;

  // a reload restarts the full interval
  always_ff @(posedge i_clock or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      count_reg <= ZERO;
      run_reg   <= 1'h0;
      o_expired <= 1'h0;
    end
    else
    begin
      o_expired <= 1'h0;
      if (i_load)
      begin
        count_reg <= LAST;
        run_reg   <= 1'h1;
      end
      else if (i_cancel)
        run_reg <= 1'h0;
      else if (run_reg && count_reg == ZERO)
      begin
        run_reg   <= 1'h0;
        o_expired <= 1'h1;
      end
      else if (run_reg)
        count_reg <= count_reg - CW'(1);
    end
  end

  property p_expire_from_zero;
    @(posedge i_clock) disable iff (!i_nrst)
    o_expired |-> $past(run_reg) && $past(count_reg) == ZERO && !$past(i_load);
  endproperty
  a_expire_from_zero: assert property (p_expire_from_zero)
    else $error("timeout fired without the count running out");

  property p_expire_single;
    @(posedge i_clock) disable iff (!i_nrst)
    o_expired |=> !o_expired && (run_reg == $past(i_load));
  endproperty
  a_expire_single: assert property (p_expire_single)
    else $error("timeout did not stop after firing");
endmodule : pcd_timer
`default_nettype wire
